/* File: src/or_pack_regs.svh */
// register offsets, field positions, encodings and reset values of the or/pack datapath
`ifndef OR_PACK_REGS_SVH
`define OR_PACK_REGS_SVH

`define FLAGS_OFS 8'h00
`define STATUS_OFS 8'h04

`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_C 1
`define FLAG_V 0
`define FLAGS_RST 4'h0

`define STATUS_KIND_MSB 2
`define STATUS_UNDEF_BIT 3
`define STATUS_UNPRED_BIT 4
`define STATUS_REDIR_BIT 5

`define REG_ALL_ONES 4'hF
`define REG_SP 4'hD

`define IMM_GRP 5'h1E
`define ORR_IMM_OP 5'h02
`define ORN_IMM_OP 5'h03
`define REG_GRP 7'h75
`define ORR_REG_OP 4'h2
`define ORN_REG_OP 4'h3
`define PACK_OP 4'h6
`define NOP_WIDE 32'hF3AF8000
`define NOP_NARROW 16'hBF00
`define ORR_NARROW_OP 10'h10C

`define LSL_TYPE 2'h0
`define LSR_TYPE 2'h1
`define ASR_TYPE 2'h2
`define SHIFT_FULL 6'h20

`endif

/* File: src/or_pack_pkg.sv */
// types shared by the or/pack datapath
package or_pack_pkg;

   typedef enum logic [2:0] {
      kind_none,
      kind_nop,
      kind_orr_imm,
      kind_orn_imm,
      kind_orr_reg,
      kind_orn_reg,
      kind_orr_narrow,
      kind_pack
   } op_kind_t;

   typedef struct packed {
      logic done;
      logic wb_en;
      logic [3:0] wb_idx;
      logic [31:0] wb_data;
      logic undef;
      logic unpred;
      logic [3:0] flags;
      logic [31:0] rdata;
      op_kind_t last_kind;
      logic last_undef;
      logic last_unpred;
      logic last_redirect;
   } state_t;

endpackage

/* File: src/immediate_expander.sv */
// modified-immediate expansion of the 12-bit immediate field with carry-out
`timescale 1ns/100ps
`include "or_pack_regs.svh"

module immediate_expander (
   // field and carry in
   input wire logic [11:0] imm12_i,
   input wire logic carry_i,
   // expanded constant
   output logic [31:0] imm32_o,
   output logic carry_o
);

   logic [7:0] byte_v;
   logic [31:0] unrot;
   logic [5:0] rot;

   always_comb begin
      byte_v = imm12_i[7:0];
      unrot = {24'h0, 1'b1, imm12_i[6:0]};
      rot = {1'b0, imm12_i[11:7]};
      imm32_o = 32'h0;
      carry_o = carry_i;
      if (imm12_i[11:10] == 2'h0) begin
         // replicated byte patterns keep the incoming carry
         case (imm12_i[9:8])
            2'h0: imm32_o = {24'h0, byte_v};
            2'h1: imm32_o = {8'h0, byte_v, 8'h0, byte_v};
            2'h2: imm32_o = {byte_v, 8'h0, byte_v, 8'h0};
            default: imm32_o = {4{byte_v}};
         endcase
      end else begin
         // rotation is at least 8 here, so both shifts stay in range
         imm32_o = (unrot >> rot) | (unrot << (`SHIFT_FULL - rot));
         carry_o = imm32_o[31];
      end
   end

endmodule

/* File: src/operand_shifter.sv */
// immediate shift decode and shifter with carry for the second operand
`timescale 1ns/100ps
`include "or_pack_regs.svh"

module operand_shifter (
   // operand and shift field
   input wire logic [31:0] value_i,
   input wire logic [1:0] type_i,
   input wire logic [4:0] imm5_i,
   input wire logic carry_i,
   // shifted operand
   output logic [31:0] result_o,
   output logic carry_o
);

   logic [5:0] amount;
   logic [32:0] wide;
   logic [31:0] rot;

   always_comb begin
      amount = {1'b0, imm5_i};
      wide = 33'h0;
      rot = 32'h0;
      result_o = value_i;
      carry_o = carry_i;
      case (type_i)
         `LSL_TYPE: begin
            wide = {1'b0, value_i} << amount;
            if (amount != 6'h00) begin
               result_o = wide[31:0];
               carry_o = wide[32];
            end
         end
         `LSR_TYPE, `ASR_TYPE: begin
            // a zero field means a full 32-bit shift
            if (imm5_i == 5'h00) begin
               amount = `SHIFT_FULL;
            end
            if (type_i == `ASR_TYPE) begin
               wide = 33'($signed({value_i, 1'b0}) >>> amount);
            end else begin
               wide = {value_i, 1'b0} >> amount;
            end
            result_o = wide[32:1];
            carry_o = wide[0];
         end
         default: begin
            if (imm5_i == 5'h00) begin
               // rotate through carry by one
               result_o = {carry_i, value_i[31:1]};
               carry_o = value_i[0];
            end else begin
               rot = (value_i >> amount) | (value_i << (`SHIFT_FULL - amount));
               result_o = rot;
               carry_o = rot[31];
            end
         end
      endcase
   end

endmodule

/* File: src/logical_or_pack_datapath.sv */
// execute stage for no-op, or, or-not and halfword pack instructions
`timescale 1ns/100ps
`include "or_pack_regs.svh"

// Function
// - no-op needs only its fixed opcode and changes no register or flag.
// - or-not immediate writes first source or inverted expanded immediate.
// - or-not immediate with first operand all ones acts as move inverted.
// - flag-setting bit one updates flags; zero leaves every flag untouched.
// - on update N takes bit 31, Z zero result, C carry, V unchanged.
// - immediate forms expand i, high and byte fields using current carry.
// - or-not register writes first source or inverted shifted operand, shifter carry.
// - or-not register with first operand all ones acts as move inverted.
// - or-not register shift comes from type field and concatenated immediates.
// - or immediate writes first source or expanded immediate.
// - or immediate with first operand all ones acts as move value.
// - narrow or reuses destination, no shift, flags only outside conditional block.
// - or register writes first source or shifted operand, carry from shifter.
// - pack with S or T bit set is undefined.
// - form select zero is bottom-top with left shift, one top-bottom arithmetic right.
// - pack shift amount comes from concatenated high and low immediates.
// - top-bottom takes low half from shifted operand; bottom-top swaps sources.
// - arithmetic right pack with zero shift field shifts by 32.
module logical_or_pack_datapath
   import or_pack_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // instruction issue
   input wire logic issue_valid_i,
   input wire logic [31:0] instr_i,
   input wire logic narrow_i,
   input wire logic in_it_block_i,
   input wire logic cond_pass_i,
   input wire logic [31:0] rn_val_i,
   input wire logic [31:0] rm_val_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // result
   output logic done_o,
   output logic wb_en_o,
   output logic [3:0] wb_idx_o,
   output logic [31:0] wb_data_o,
   output logic undefined_o,
   output logic unpredictable_o,
   output logic [3:0] flags_o
);

   state_t st_r;
   state_t st_nxt;

   logic [15:0] hw1;
   logic [15:0] hw2;
   logic [3:0] rn_f;
   logic [3:0] rd_f;
   logic [3:0] rm_f;
   logic set_bit;
   logic pack_form_select;
   logic pack_t_bit;
   logic [2:0] imm_hi_field;
   logic [1:0] imm_lo_field;
   logic [7:0] imm_byte_field;
   op_kind_t kind;
   logic redirect;
   logic setflags;
   logic [1:0] sh_type;
   logic [4:0] sh_imm5;
   logic [31:0] imm32;
   logic imm_carry;
   logic [31:0] shifted;
   logic sh_carry;
   logic [31:0] op1;
   logic [31:0] op2;
   logic [31:0] result;
   logic res_carry;

   assign hw1 = instr_i[31:16];
   assign hw2 = instr_i[15:0];
   assign rn_f = hw1[3:0];
   assign rd_f = hw2[11:8];
   assign rm_f = hw2[3:0];
   assign set_bit = hw1[4];
   assign pack_form_select = hw2[5];
   assign pack_t_bit = hw2[4];
   assign imm_hi_field = hw2[14:12];
   assign imm_lo_field = hw2[7:6];
   assign imm_byte_field = hw2[7:0];

   // opcode recognition; no-op matches its fixed pattern and nothing else
   always_comb begin
      kind = kind_none;
      if (narrow_i) begin
         if (hw2 == `NOP_NARROW) begin
            kind = kind_nop;
         end else if (hw2[15:6] == `ORR_NARROW_OP) begin
            kind = kind_orr_narrow;
         end
      end else if (instr_i == `NOP_WIDE) begin
         kind = kind_nop;
      end else if (hw1[15:11] == `IMM_GRP && !hw2[15]) begin
         if (hw1[9:5] == `ORR_IMM_OP) begin
            kind = kind_orr_imm;
         end else if (hw1[9:5] == `ORN_IMM_OP) begin
            kind = kind_orn_imm;
         end
      end else if (hw1[15:9] == `REG_GRP && !hw2[15]) begin
         case (hw1[8:5])
            `ORR_REG_OP: kind = kind_orr_reg;
            `ORN_REG_OP: kind = kind_orn_reg;
            `PACK_OP: kind = kind_pack;
            default: kind = kind_none;
         endcase
      end
   end

   // shift selection: narrow form is a zero-length left shift
   always_comb begin
      sh_type = hw2[5:4];
      sh_imm5 = {imm_hi_field, imm_lo_field};
      if (kind == kind_orr_narrow) begin
         sh_type = `LSL_TYPE;
         sh_imm5 = 5'h00;
      end else if (kind == kind_pack) begin
         // form select picks left or arithmetic right shift
         sh_type = {pack_form_select, 1'b0};
      end
   end

   immediate_expander u_expander (
      .imm12_i({hw1[10], imm_hi_field, imm_byte_field}),
      .carry_i(st_r.flags[`FLAG_C]),
      .imm32_o(imm32),
      .carry_o(imm_carry)
   );

   operand_shifter u_shifter (
      .value_i(rm_val_i),
      .type_i(sh_type),
      .imm5_i(sh_imm5),
      .carry_i(st_r.flags[`FLAG_C]),
      .result_o(shifted),
      .carry_o(sh_carry)
   );

   // operand path; a redirected form ors with zero, giving a move, or a move inverted for or-not forms
   always_comb begin
      redirect = (rn_f == `REG_ALL_ONES) && (kind == kind_orr_imm || kind == kind_orn_imm ||
         kind == kind_orr_reg || kind == kind_orn_reg);
      op1 = redirect ? 32'h0 : rn_val_i;
      op2 = shifted;
      res_carry = sh_carry;
      if (kind == kind_orr_imm || kind == kind_orn_imm) begin
         op2 = imm32;
         res_carry = imm_carry;
      end
      if (kind == kind_orn_imm || kind == kind_orn_reg) begin
         result = op1 | ~op2;
      end else begin
         result = op1 | op2;
      end
      if (kind == kind_pack) begin
         if (pack_form_select) begin
            result = {rn_val_i[31:16], shifted[15:0]};
         end else begin
            result = {shifted[31:16], rn_val_i[15:0]};
         end
      end
      setflags = (kind == kind_orr_narrow) ? !in_it_block_i : set_bit;
   end

   // execute, flag update and register port
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.wb_en = 1'b0;
      st_nxt.undef = 1'b0;
      st_nxt.unpred = 1'b0;
      if (reg_wr_i && reg_addr_i == `FLAGS_OFS) begin
         st_nxt.flags = reg_wdata_i[3:0];
      end
      if (issue_valid_i && kind != kind_none) begin
         st_nxt.done = 1'b1;
         st_nxt.last_kind = kind;
         st_nxt.last_redirect = redirect;
         st_nxt.undef = (kind == kind_pack) && (set_bit || pack_t_bit);
         // reserved registers are only reported; the outcome is left as computed
         if (kind == kind_pack) begin
            st_nxt.unpred = (rd_f == `REG_SP) || (rd_f == `REG_ALL_ONES) ||
               (rn_f == `REG_SP) || (rn_f == `REG_ALL_ONES) ||
               (rm_f == `REG_SP) || (rm_f == `REG_ALL_ONES);
         end else if (kind != kind_nop && kind != kind_orr_narrow) begin
            st_nxt.unpred = (rd_f == `REG_SP) || (rd_f == `REG_ALL_ONES) ||
               (!redirect && rn_f == `REG_SP);
            if (kind == kind_orr_reg || kind == kind_orn_reg) begin
               st_nxt.unpred = st_nxt.unpred || (rm_f == `REG_SP) ||
                  (rm_f == `REG_ALL_ONES);
            end
         end
         st_nxt.last_undef = st_nxt.undef;
         st_nxt.last_unpred = st_nxt.unpred;
         if (cond_pass_i && kind != kind_nop && !st_nxt.undef) begin
            st_nxt.wb_en = 1'b1;
            st_nxt.wb_data = result;
            st_nxt.wb_idx = (kind == kind_orr_narrow) ? {1'b0, hw2[2:0]} : rd_f;
            if (setflags && kind != kind_pack) begin
               // instruction update of N, Z and C wins over a software flag write in the same cycle; V keeps the written value
               st_nxt.flags[`FLAG_N] = result[31];
               st_nxt.flags[`FLAG_Z] = (result == 32'h0);
               st_nxt.flags[`FLAG_C] = res_carry;
            end
         end
      end
      st_nxt.rdata = 32'h0;
      if (reg_rd_i) begin
         if (reg_addr_i == `FLAGS_OFS) begin
            st_nxt.rdata[3:0] = st_r.flags;
         end else if (reg_addr_i == `STATUS_OFS) begin
            st_nxt.rdata[`STATUS_KIND_MSB:0] = st_r.last_kind;
            st_nxt.rdata[`STATUS_UNDEF_BIT] = st_r.last_undef;
            st_nxt.rdata[`STATUS_UNPRED_BIT] = st_r.last_unpred;
            st_nxt.rdata[`STATUS_REDIR_BIT] = st_r.last_redirect;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_o = st_r.rdata;
   assign done_o = st_r.done;
   assign wb_en_o = st_r.wb_en;
   assign wb_idx_o = st_r.wb_idx;
   assign wb_data_o = st_r.wb_data;
   assign undefined_o = st_r.undef;
   assign unpredictable_o = st_r.unpred;
   assign flags_o = st_r.flags;

   // checks; a software flag write in the same cycle is kept out of all of them but a_pack_undef and c_cond_fail
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   logic issue_ok;
   assign issue_ok = issue_valid_i && cond_pass_i && !reg_wr_i;

   property p_nop_quiet;
      issue_ok && kind == kind_nop |=> done_o && !wb_en_o && $stable(flags_o);
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("no-op changed state");

   property p_cond_fail;
      issue_valid_i && !cond_pass_i && !reg_wr_i |=> !wb_en_o && $stable(flags_o);
   endproperty
   a_cond_fail: assert property (p_cond_fail) else $error("failed condition wrote");

   property p_no_setflags;
      issue_ok && (kind == kind_orr_imm || kind == kind_orn_reg) && !set_bit
         |=> wb_en_o && $stable(flags_o);
   endproperty
   a_no_setflags: assert property (p_no_setflags) else $error("flags moved");

   property p_flag_values;
      issue_ok && kind == kind_orn_imm && set_bit |=> flags_o[`FLAG_N] == wb_data_o[31] &&
         flags_o[`FLAG_Z] == (wb_data_o == 32'h0) &&
         flags_o[`FLAG_C] == $past(imm_carry) && flags_o[`FLAG_V] == $past(flags_o[`FLAG_V]);
   endproperty
   a_flag_values: assert property (p_flag_values) else $error("flag values wrong");

   property p_orn_imm;
      issue_ok && kind == kind_orn_imm && !redirect
         |=> wb_data_o == ($past(rn_val_i) | ~$past(imm32)) && wb_idx_o == $past(rd_f);
   endproperty
   a_orn_imm: assert property (p_orn_imm) else $error("or-not immediate wrong");

   property p_move_inverted;
      issue_ok && kind == kind_orn_imm && redirect |=> wb_data_o == ~$past(imm32);
   endproperty
   a_move_inverted: assert property (p_move_inverted) else $error("move inverted wrong");

   property p_move_value;
      issue_ok && kind == kind_orr_imm && redirect |=> wb_data_o == $past(imm32);
   endproperty
   a_move_value: assert property (p_move_value) else $error("move value wrong");

   property p_orr_imm;
      issue_ok && kind == kind_orr_imm && !redirect
         |=> wb_data_o == ($past(rn_val_i) | $past(imm32));
   endproperty
   a_orr_imm: assert property (p_orr_imm) else $error("or immediate wrong");

   property p_orn_reg_move;
      issue_ok && kind == kind_orn_reg && redirect |=> wb_data_o == ~$past(shifted);
   endproperty
   a_orn_reg_move: assert property (p_orn_reg_move) else $error("inverted move wrong");

   property p_narrow_in_block;
      issue_ok && kind == kind_orr_narrow && in_it_block_i
         |=> wb_en_o && $stable(flags_o) && wb_data_o == ($past(rn_val_i) | $past(rm_val_i));
   endproperty
   a_narrow_in_block: assert property (p_narrow_in_block) else $error("narrow or wrong");

   property p_pack_undef;
      issue_valid_i && kind == kind_pack && (set_bit || pack_t_bit)
         |=> undefined_o && !wb_en_o;
   endproperty
   a_pack_undef: assert property (p_pack_undef) else $error("pack not undefined");

   property p_pack_tb_full;
      issue_ok && kind == kind_pack && pack_form_select && !set_bit && !pack_t_bit &&
         sh_imm5 == 5'h00 |=> wb_data_o[15:0] == {16{$past(rm_val_i[31])}} &&
         wb_data_o[31:16] == $past(rn_val_i[31:16]);
   endproperty
   a_pack_tb_full: assert property (p_pack_tb_full) else $error("pack shift wrong");

   property p_orn_reg;
      issue_ok && kind == kind_orn_reg && !redirect
         |=> wb_data_o == ($past(rn_val_i) | ~$past(shifted));
   endproperty
   a_orn_reg: assert property (p_orn_reg) else $error("or-not register wrong");

   property p_orr_reg;
      issue_ok && kind == kind_orr_reg && !redirect
         |=> wb_data_o == ($past(rn_val_i) | $past(shifted));
   endproperty
   a_orr_reg: assert property (p_orr_reg) else $error("or register wrong");

   property p_pack_bt;
      issue_ok && kind == kind_pack && !pack_form_select && !set_bit && !pack_t_bit
         |=> wb_data_o[15:0] == $past(rn_val_i[15:0]);
   endproperty
   a_pack_bt: assert property (p_pack_bt) else $error("pack low half wrong");

   // pack never moves the flags, whatever its flag-setting bit says
   property p_pack_flags;
      issue_ok && kind == kind_pack |=> $stable(flags_o);
   endproperty
   a_pack_flags: assert property (p_pack_flags) else $error("pack moved flags");

   c_pack_bt: cover property (issue_ok && kind == kind_pack && !pack_form_select ##1 wb_en_o);
   c_orn_flags: cover property (issue_ok && kind == kind_orn_reg && set_bit ##1 wb_en_o);
   c_redirect: cover property (issue_ok && redirect ##1 wb_en_o);
   c_cond_fail: cover property (issue_valid_i && !cond_pass_i && kind != kind_none ##1 done_o);

endmodule

/* File: verif/logical_or_pack_datapath_tb.sv */
// self-checking testbench for the or/pack datapath
`timescale 1ns/100ps
`include "or_pack_regs.svh"

module logical_or_pack_datapath_tb;
   import or_pack_pkg::*;

   logic clock_i;
   logic rst_n_i;
   logic issue_valid_i;
   logic [31:0] instr_i;
   logic narrow_i;
   logic in_it_block_i;
   logic cond_pass_i;
   logic [31:0] rn_val_i;
   logic [31:0] rm_val_i;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic done_o;
   logic wb_en_o;
   logic [3:0] wb_idx_o;
   logic [31:0] wb_data_o;
   logic undefined_o;
   logic unpredictable_o;
   logic [3:0] flags_o;
   int error_cnt = 0;
   int checks = 0;
   int cycle_cnt = 0;
   logic [31:0] rd_val;

   logical_or_pack_datapath DUT (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .issue_valid_i(issue_valid_i),
      .instr_i(instr_i),
      .narrow_i(narrow_i),
      .in_it_block_i(in_it_block_i),
      .cond_pass_i(cond_pass_i),
      .rn_val_i(rn_val_i),
      .rm_val_i(rm_val_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o),
      .done_o(done_o),
      .wb_en_o(wb_en_o),
      .wb_idx_o(wb_idx_o),
      .wb_data_o(wb_data_o),
      .undefined_o(undefined_o),
      .unpredictable_o(unpredictable_o),
      .flags_o(flags_o)
   );

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // generous ceiling: the whole sequence needs about a hundred cycles
   always @(posedge clock_i) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // wide immediate form: i, imm_hi_field and imm_byte_field split from a 12-bit field
   function automatic logic [31:0] imm_enc(input logic [4:0] op, input logic s,
         input logic [3:0] rn, input logic [3:0] rd, input logic [11:0] imm12);
      return {`IMM_GRP, imm12[11], op, s, rn, 1'b0, imm12[10:8], rd, imm12[7:0]};
   endfunction

   // wide register form: shift field is imm_hi_field then imm_lo_field
   function automatic logic [31:0] reg_enc(input logic [3:0] op, input logic s,
         input logic [3:0] rn, input logic [3:0] rd, input logic [4:0] sh,
         input logic [1:0] typ, input logic [3:0] rm);
      return {`REG_GRP, op, s, rn, 1'b0, sh[4:2], rd, sh[1:0], typ, rm};
   endfunction

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
      @(posedge clock_i);
      #1;
      check("rdata idle", reg_rdata_o, 32'h00000000);
   endtask

   task automatic exec(input logic [31:0] ins, input logic nar, input logic it,
         input logic cp, input logic [31:0] rn, input logic [31:0] rm);
      @(posedge clock_i);
      issue_valid_i <= 1'b1;
      instr_i <= ins;
      narrow_i <= nar;
      in_it_block_i <= it;
      cond_pass_i <= cp;
      rn_val_i <= rn;
      rm_val_i <= rm;
      @(posedge clock_i);
      issue_valid_i <= 1'b0;
      #1;
   endtask

   task automatic expect_out(input logic en, input logic [3:0] idx, input logic [31:0] data,
         input logic [3:0] flg, input logic und, input logic unp);
      check("done", done_o, 32'h00000001);
      check("wb_en", wb_en_o, en);
      if (en) begin
         check("wb_idx", wb_idx_o, idx);
      end
      check("wb_data", wb_data_o, data);
      check("flags", flags_o, flg);
      check("undefined", undefined_o, und);
      check("unpredictable", unpredictable_o, unp);
      @(posedge clock_i);
      #1;
      check("done pulse", done_o, 32'h00000000);
      check("wb_en pulse", wb_en_o, 32'h00000000);
   endtask

   initial begin
      rst_n_i = 1'b0;
      issue_valid_i = 1'b0;
      instr_i = 32'h00000000;
      narrow_i = 1'b0;
      in_it_block_i = 1'b0;
      cond_pass_i = 1'b1;
      rn_val_i = 32'h00000000;
      rm_val_i = 32'h00000000;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h00000000;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      check("flags after reset", flags_o, 32'h00000000);
      check("done after reset", done_o, 32'h00000000);
      // register port: write, read back, read-only status, unmapped place
      reg_write(`FLAGS_OFS, 32'h0000000F);
      check("flags written", flags_o, 32'h0000000F);
      reg_read(`FLAGS_OFS, rd_val);
      check("flags read", rd_val, 32'h0000000F);
      reg_write(`STATUS_OFS, 32'h000000FF);
      reg_read(`STATUS_OFS, rd_val);
      check("status read only", rd_val, 32'h00000000);
      reg_read(8'h10, rd_val);
      check("unmapped read", rd_val, 32'h00000000);
      // V set beforehand so that a flag update must leave it alone
      reg_write(`FLAGS_OFS, 32'h00000001);
      exec(imm_enc(`ORR_IMM_OP, 1'b1, 4'h1, 4'h2, 12'h400), 1'b0, 1'b0, 1'b1,
         32'h00000001, 32'h0);
      expect_out(1'b1, 4'h2, 32'h80000001, 4'hB, 1'b0, 1'b0);
      exec(imm_enc(`ORN_IMM_OP, 1'b0, 4'h1, 4'h3, 12'h0FF), 1'b0, 1'b0, 1'b1,
         32'hFFFF0000, 32'h0);
      expect_out(1'b1, 4'h3, 32'hFFFFFF00, 4'hB, 1'b0, 1'b0);
      // replicated-byte constant keeps the carry flag as its carry-out
      for (int c = 0; c < 2; c++) begin
         reg_write(`FLAGS_OFS, (c == 1) ? 32'h00000002 : 32'h00000004);
         exec(imm_enc(`ORN_IMM_OP, 1'b1, 4'h1, 4'h3, 12'h1AB), 1'b0, 1'b0, 1'b1,
            32'h00000000, 32'h0);
         expect_out(1'b1, 4'h3, 32'hFF54FF54, (c == 1) ? 4'hA : 4'h8, 1'b0, 1'b0);
      end
      exec(imm_enc(`ORN_IMM_OP, 1'b0, `REG_ALL_ONES, 4'h4, 12'h0FF), 1'b0, 1'b0, 1'b1,
         32'h12345678, 32'h0);
      expect_out(1'b1, 4'h4, 32'hFFFFFF00, 4'hA, 1'b0, 1'b0);
      reg_read(`STATUS_OFS, rd_val);
      check("redirect", rd_val[`STATUS_REDIR_BIT], 32'h00000001);
      exec(imm_enc(`ORR_IMM_OP, 1'b0, `REG_ALL_ONES, 4'h4, 12'h0FF), 1'b0, 1'b0, 1'b1,
         32'hFFFFFFFF, 32'h0);
      expect_out(1'b1, 4'h4, 32'h000000FF, 4'hA, 1'b0, 1'b0);
      // shift field zero with the right-shift type means a full 32-bit shift
      exec(reg_enc(`ORN_REG_OP, 1'b1, 4'h1, 4'h5, 5'h00, `LSR_TYPE, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h00000000, 32'h80000000);
      expect_out(1'b1, 4'h5, 32'hFFFFFFFF, 4'hA, 1'b0, 1'b0);
      exec(reg_enc(`ORN_REG_OP, 1'b1, 4'h1, 4'h5, 5'h04, `ASR_TYPE, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h00000000, 32'h80000008);
      expect_out(1'b1, 4'h5, 32'h07FFFFFF, 4'h2, 1'b0, 1'b0);
      exec(reg_enc(`ORN_REG_OP, 1'b0, `REG_ALL_ONES, 4'h6, 5'h00, `LSL_TYPE, 4'h2),
         1'b0, 1'b0, 1'b1, 32'hFFFFFFFF, 32'h0000FFFF);
      expect_out(1'b1, 4'h6, 32'hFFFF0000, 4'h2, 1'b0, 1'b0);
      exec(reg_enc(`ORR_REG_OP, 1'b1, 4'h1, 4'h7, 5'h04, `LSL_TYPE, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h00000000, 32'h1F000000);
      expect_out(1'b1, 4'h7, 32'hF0000000, 4'hA, 1'b0, 1'b0);
      exec(reg_enc(`ORR_REG_OP, 1'b1, 4'h1, 4'h7, 5'h00, `LSL_TYPE, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h00000000, 32'h00000000);
      expect_out(1'b1, 4'h7, 32'h00000000, 4'h6, 1'b0, 1'b0);
      // narrow or: destination is the first operand, flags only outside a conditional block
      reg_write(`FLAGS_OFS, 32'h00000000);
      exec({16'h0000, `ORR_NARROW_OP, 3'h2, 3'h5}, 1'b1, 1'b0, 1'b1,
         32'h80000000, 32'h00000001);
      expect_out(1'b1, 4'h5, 32'h80000001, 4'h8, 1'b0, 1'b0);
      exec({16'h0000, `ORR_NARROW_OP, 3'h2, 3'h5}, 1'b1, 1'b1, 1'b1,
         32'h00000000, 32'h00000000);
      expect_out(1'b1, 4'h5, 32'h00000000, 4'h8, 1'b0, 1'b0);
      // pack forms; flags must stay at 8 throughout
      exec(reg_enc(`PACK_OP, 1'b0, 4'h1, 4'h6, 5'h04, 2'h0, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h12345678, 32'h0ABC0000);
      expect_out(1'b1, 4'h6, 32'hABC05678, 4'h8, 1'b0, 1'b0);
      exec(reg_enc(`PACK_OP, 1'b0, 4'h1, 4'h6, 5'h00, 2'h2, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h12345678, 32'h80000000);
      expect_out(1'b1, 4'h6, 32'h1234FFFF, 4'h8, 1'b0, 1'b0);
      exec(reg_enc(`PACK_OP, 1'b0, 4'h1, 4'h6, 5'h08, 2'h2, 4'h2), 1'b0, 1'b0, 1'b1,
         32'h12345678, 32'h0000AB00);
      expect_out(1'b1, 4'h6, 32'h123400AB, 4'h8, 1'b0, 1'b0);
      for (int k = 0; k < 2; k++) begin
         exec(reg_enc(`PACK_OP, k == 0, 4'h1, 4'h6, 5'h00, {1'b0, k == 1}, 4'h2),
            1'b0, 1'b0, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF);
         expect_out(1'b0, 4'h6, 32'h123400AB, 4'h8, 1'b1, 1'b0);
      end
      // a failed condition must not write or touch flags
      exec(imm_enc(`ORR_IMM_OP, 1'b1, 4'h1, 4'h2, 12'h400), 1'b0, 1'b0, 1'b0,
         32'hFFFFFFFF, 32'h0);
      expect_out(1'b0, 4'h2, 32'h123400AB, 4'h8, 1'b0, 1'b0);
      exec(`NOP_WIDE, 1'b0, 1'b0, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF);
      expect_out(1'b0, 4'h2, 32'h123400AB, 4'h8, 1'b0, 1'b0);
      exec({16'h0000, `NOP_NARROW}, 1'b1, 1'b0, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF);
      expect_out(1'b0, 4'h2, 32'h123400AB, 4'h8, 1'b0, 1'b0);
      // reserved destination or second source is only flagged, the result is still written
      exec(imm_enc(`ORR_IMM_OP, 1'b0, 4'h1, `REG_SP, 12'h0FF), 1'b0, 1'b0, 1'b1,
         32'h00000100, 32'h0);
      expect_out(1'b1, `REG_SP, 32'h000001FF, 4'h8, 1'b0, 1'b1);
      exec(reg_enc(`ORR_REG_OP, 1'b0, 4'h1, 4'h7, 5'h00, `LSL_TYPE, `REG_SP), 1'b0, 1'b0,
         1'b1, 32'h00000001, 32'h00000002);
      expect_out(1'b1, 4'h7, 32'h00000003, 4'h8, 1'b0, 1'b1);
      end_of_test();
   end
endmodule
